/* verilog/tbsel_map.svh */
// Byte codes, frame positions, sizes and timing of the Type B selection block.
`ifndef TBSEL_MAP_SVH
`define TBSEL_MAP_SVH
`define TB_FRAME_MAX     16
`define TB_CMD_REQB      8'h05
`define TB_CMD_ATTRIB    8'h1d
`define TB_CMD_DSL       8'hc2
`define TB_CMD_DSL_CID   8'hca
`define TB_HL_UID_READ   8'h30
`define TB_HL_STATUS_OK  8'h00
`define TB_MBLI_NONE     4'h0
`define TB_REQ_LEN       5'h03
`define TB_ATTR_LEN      5'h09
`define TB_ATTR_HL_LEN   5'h0a
`define TB_UID_RESP_LEN  5'h0a
`define TB_IND_RESP_LEN  5'h01
`define TB_DSL_LEN       5'h01
`define TB_DSL_CID_LEN   5'h02
`define TB_POS_AFI       1
`define TB_POS_PARAM     2
`define TB_POS_PUPI      1
`define TB_POS_P2        6
`define TB_POS_P4        8
`define TB_POS_HL        9
`define TB_POS_CID       1
`define TB_POS_UID_RESP  2
`define TB_WUPB_BIT      3
`define TB_NCODE_MAX     3'h4
`define TB_LFSR_SEED     16'hace1
`define TB_CLK_NS        8
`define TB_TR0_NS        151000
`endif

/* verilog/tbsel_pkg.sv */
// Types shared by the Type B selection block.
package tbsel_pkg;
  typedef logic [7:0] tbsel_byte_t;
  typedef enum logic [1:0] {st_idle, st_ready, st_active, st_halt} tbsel_state_t;
endpackage

/* verilog/tbsel_if.sv */
// Frame handover between the core domain and the link-side receiver and transmitter.
`include "tbsel_map.svh"
interface tbsel_if;
  import tbsel_pkg::*;
  tbsel_byte_t rx_buf [`TB_FRAME_MAX];
  logic [4:0]  rx_len;
  logic        rx_crc_ok;
  logic        rx_tgl;
  logic        rx_ack_tgl;
  tbsel_byte_t tx_buf [`TB_FRAME_MAX];
  logic [4:0]  tx_len;
  logic        tx_tgl;
  logic        tx_done_tgl;
  modport core (input rx_buf, rx_len, rx_crc_ok, rx_tgl, tx_done_tgl,
                output rx_ack_tgl, tx_buf, tx_len, tx_tgl);
  modport rx (output rx_buf, rx_len, rx_crc_ok, rx_tgl, input rx_ack_tgl);
  modport tx (input tx_buf, tx_len, tx_tgl, output tx_done_tgl);
endinterface

/* verilog/tbsel_rx.sv */
// Link-side frame collector: gathers request bytes and hands a whole frame to the core.
`include "tbsel_map.svh"
module tbsel_rx (
  input  wire logic lk_clk_in,   // Link clock.
  input  wire logic rst_in,      // Asynchronous reset, active high.
  input  wire logic [7:0] data_in, // Received byte.
  input  wire logic valid_in,    // Byte strobe.
  input  wire logic eof_in,      // End of frame strobe.
  input  wire logic crc_ok_in,   // Frame CRC good, valid with eof_in.
  tbsel_if.rx       lnk          // Frame handover.
);
  import tbsel_pkg::*;
  tbsel_byte_t buf_r [`TB_FRAME_MAX];
  logic [4:0]  cnt_r;
  logic [4:0]  len_r;
  logic        spoil_r;
  logic        crc_r;
  logic        tgl_r;
  logic        ack_s1_r;
  logic        ack_s2_r;
  logic        busy;

  // The frame stays frozen until the core acknowledges it, so the words cross safely.
  assign busy = tgl_r != ack_s2_r;

  for (genvar gi = 0; gi < `TB_FRAME_MAX; gi++) begin : g_byte
    always_ff @(posedge lk_clk_in or posedge rst_in) begin
      if (rst_in) begin
        buf_r[gi] <= 8'h00;
      end else if (valid_in && !busy && cnt_r == 5'(gi)) begin
        buf_r[gi] <= data_in;
      end
    end
    assign lnk.rx_buf[gi] = buf_r[gi];
  end

  // Bytes seen while busy or past the buffer spoil the frame, which the core then drops.
  always_ff @(posedge lk_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r   <= 5'h00;
      spoil_r <= 1'b0;
    end else if (eof_in) begin
      cnt_r   <= 5'h00;
      spoil_r <= 1'b0;
    end else if (valid_in) begin
      if (busy || cnt_r == 5'(`TB_FRAME_MAX)) begin
        spoil_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  always_ff @(posedge lk_clk_in or posedge rst_in) begin
    if (rst_in) begin
      len_r <= 5'h00;
      crc_r <= 1'b0;
      tgl_r <= 1'b0;
    end else if (eof_in && !busy) begin
      len_r <= cnt_r;
      crc_r <= crc_ok_in && !spoil_r;
      tgl_r <= !tgl_r;
    end
  end

  always_ff @(posedge lk_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= lnk.rx_ack_tgl;
      ack_s2_r <= ack_s1_r;
    end
  end

  assign lnk.rx_len    = len_r;
  assign lnk.rx_crc_ok = crc_r;
  assign lnk.rx_tgl    = tgl_r;
endmodule

/* verilog/tbsel_tx.sv */
// Link-side response sender: streams a staged response out byte by byte.
`include "tbsel_map.svh"
module tbsel_tx (
  input  wire logic       lk_clk_in, // Link clock.
  input  wire logic       rst_in,    // Asynchronous reset, active high.
  input  wire logic       ready_in,  // Modulator takes the byte.
  output tbsel_pkg::tbsel_byte_t data_out, // Response byte.
  output logic            valid_out, // Response byte valid.
  tbsel_if.tx             lnk        // Response handover.
);
  import tbsel_pkg::*;
  logic       tgl_s1_r;
  logic       tgl_s2_r;
  logic       seen_r;
  logic       done_r;
  logic [4:0] idx_r;
  logic       start;

  assign start = (tgl_s2_r != seen_r) && !valid_out;

  always_ff @(posedge lk_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
    end else begin
      tgl_s1_r <= lnk.tx_tgl;
      tgl_s2_r <= tgl_s1_r;
    end
  end

  always_ff @(posedge lk_clk_in or posedge rst_in) begin
    if (rst_in) begin
      seen_r    <= 1'b0;
      done_r    <= 1'b0;
      idx_r     <= 5'h00;
      data_out  <= 8'h00;
      valid_out <= 1'b0;
    end else if (start) begin
      seen_r    <= tgl_s2_r;
      data_out  <= lnk.tx_buf[0];
      idx_r     <= 5'h01;
      valid_out <= 1'b1;
    end else if (valid_out && ready_in) begin
      if (idx_r == lnk.tx_len) begin
        valid_out <= 1'b0;
        done_r    <= !done_r;
      end else begin
        data_out <= lnk.tx_buf[idx_r[3:0]];
        idx_r    <= idx_r + 5'h01;
      end
    end
  end

  assign lnk.tx_done_tgl = done_r;
endmodule

/* verilog/tbsel_top.sv */
// Type B selection, release and probabilistic anticollision for a contactless tag.
//
// Notes on behaviour
// - Rate codes 00b..11b pick 105.9 to 847.5kbps.
// - Request and response rates are set independently.
// - Frame size nibble of parameter two ignored.
// - Only embedded identifier read 30h executes.
// - Selection answered only with own PUPI, good CRC.
// - Indicator byte: 0000b then assigned identifier.
// - Identifier read appends 00h and eight UID bytes.
// - Release is C2h alone or CAh plus identifier.
// - Accepted release moves ACTIVE to HALT.
// - Release with identifier needs matching identifier.
// - Release without identifier needs identifier zero.
// - Release answer echoes the received bytes.
// - Wake-up works in HALT; normal request does not.
// - N=1 answers; else answer only when R=1.
// - Losing draw stays silent until next request or a selection with own PUPI.
// - ACTIVE ignores all but release.
// - Selection 1Dh with PUPI is only way to ACTIVE.
// - Parameter one ignored; fixed 151000 ns turnaround.
// - PUPI is the low four UID bytes.
// - HALT answers only the wake-up request.
`include "tbsel_map.svh"
module tbsel_top #(
  parameter int unsigned TR0_CYCLES = (`TB_TR0_NS + `TB_CLK_NS - 1) / `TB_CLK_NS
) (
  input  wire logic        clock_in,        // Core clock, 125 MHz.
  input  wire logic        rst_in,          // Asynchronous reset, active high.
  input  wire logic        link_clk_in,     // Link clock from the demodulator.
  input  wire logic [7:0]  lk_rx_data_in,   // Received byte, link domain.
  input  wire logic        lk_rx_valid_in,  // Received byte strobe.
  input  wire logic        lk_rx_eof_in,    // End of received frame.
  input  wire logic        lk_rx_crc_ok_in, // Received frame CRC good.
  input  wire logic        lk_tx_ready_in,  // Modulator takes a response byte.
  input  wire logic [63:0] uid_in,          // Unique identifier.
  input  wire logic [7:0]  afi_in,          // Own family identifier.
  output tbsel_pkg::tbsel_byte_t lk_tx_data_out, // Response byte, link domain.
  output logic             lk_tx_valid_out, // Response byte valid.
  output logic             atqb_req_out,    // Pulse: send the request answer.
  output tbsel_pkg::tbsel_state_t state_out, // Selection state.
  output logic [3:0]       cid_out,         // Assigned card identifier.
  output logic             cid_valid_out,   // Identifier has been assigned.
  output logic [1:0]       up_rate_out,     // Response rate code.
  output logic [1:0]       down_rate_out    // Request rate code.
);
  import tbsel_pkg::*;

  tbsel_if lnk ();

  tbsel_state_t state_r;
  tbsel_byte_t  tx_buf_r [`TB_FRAME_MAX];
  tbsel_byte_t  resp_nxt [`TB_FRAME_MAX];
  logic [4:0]   tx_len_r;
  logic [4:0]   resp_len_nxt;
  logic         rx_s1_r;
  logic         rx_s2_r;
  logic         done_s1_r;
  logic         done_s2_r;
  logic         seen_r;
  logic         tx_tgl_r;
  logic         pend_r;
  logic [15:0]  guard_r;
  logic [15:0]  lfsr_r;
  logic         take;
  logic         tx_busy;
  logic         req_hit;
  logic         draw_win;
  logic         attr_hit;
  logic         uid_rd;
  logic         dsl_hit;
  logic         pupi_ok;
  logic [3:0]   slot_mask;
  tbsel_byte_t  cmd;
  tbsel_byte_t  prm;
  tbsel_byte_t  afi_req;

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  tbsel_rx u_rx (
    .lk_clk_in (link_clk_in),
    .rst_in    (rst_in),
    .data_in   (lk_rx_data_in),
    .valid_in  (lk_rx_valid_in),
    .eof_in    (lk_rx_eof_in),
    .crc_ok_in (lk_rx_crc_ok_in),
    .lnk       (lnk.rx)
  );

  tbsel_tx u_tx (
    .lk_clk_in (link_clk_in),
    .rst_in    (rst_in),
    .ready_in  (lk_tx_ready_in),
    .data_out  (lk_tx_data_out),
    .valid_out (lk_tx_valid_out),
    .lnk       (lnk.tx)
  );

  // ----------------------------------------------------------------
  // Crossing
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rx_s1_r   <= 1'b0;
      rx_s2_r   <= 1'b0;
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
    end else begin
      rx_s1_r   <= lnk.rx_tgl;
      rx_s2_r   <= rx_s1_r;
      done_s1_r <= lnk.tx_done_tgl;
      done_s2_r <= done_s1_r;
    end
  end

  // A new frame waits while a response is still pending, so nothing is overwritten.
  assign tx_busy = pend_r || (tx_tgl_r != done_s2_r);
  assign take    = (rx_s2_r != seen_r) && !tx_busy;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      seen_r <= 1'b0;
    end else if (take) begin
      seen_r <= rx_s2_r;
    end
  end

  assign lnk.rx_ack_tgl = seen_r;

  // ----------------------------------------------------------------
  // Random source
  // ----------------------------------------------------------------
  // Free-running draw source.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      lfsr_r <= `TB_LFSR_SEED;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign cmd     = lnk.rx_buf[0];
  assign afi_req = lnk.rx_buf[`TB_POS_AFI];
  assign prm     = lnk.rx_buf[`TB_POS_PARAM];
  // N is a power of two, so masking the generator gives R-1 uniform over the slots.
  assign slot_mask = 4'((5'h01 << prm[2:0]) - 5'h01);

  // PUPI compared against the low UID bytes.
  assign pupi_ok = {lnk.rx_buf[`TB_POS_PUPI], lnk.rx_buf[`TB_POS_PUPI + 1],
                    lnk.rx_buf[`TB_POS_PUPI + 2], lnk.rx_buf[`TB_POS_PUPI + 3]}
                   == uid_in[31:0];

  always_comb begin
    // Wake-up passes HALT, normal request does not.
    req_hit = lnk.rx_crc_ok && lnk.rx_len == `TB_REQ_LEN && cmd == `TB_CMD_REQB
              && state_r != st_active && prm[2:0] <= `TB_NCODE_MAX
              && (prm[`TB_WUPB_BIT] || state_r != st_halt)
              && (afi_req == 8'h00 || afi_req == afi_in
                  || (afi_req[3:0] == 4'h0 && afi_req[7:4] == afi_in[7:4]));
    // Answer only when the draw lands on the first slot.
    draw_win = (lfsr_r[3:0] & slot_mask) == 4'h0;
    // Selection needs own PUPI and good CRC.
    attr_hit = lnk.rx_crc_ok && lnk.rx_len >= `TB_ATTR_LEN && cmd == `TB_CMD_ATTRIB
               && pupi_ok && (state_r == st_idle || state_r == st_ready);
    // Only the identifier read is executed.
    uid_rd = lnk.rx_len >= `TB_ATTR_HL_LEN && lnk.rx_buf[`TB_POS_HL] == `TB_HL_UID_READ;
    dsl_hit = lnk.rx_crc_ok && state_r == st_active
              && ((lnk.rx_len == `TB_DSL_LEN && cmd == `TB_CMD_DSL && cid_out == 4'h0)
                  || (lnk.rx_len == `TB_DSL_CID_LEN && cmd == `TB_CMD_DSL_CID
                      && lnk.rx_buf[`TB_POS_CID][3:0] == cid_out));
  end

  // Release answer echoes the request by default.
  // Indicator: no buffer size, new identifier.
  // Identifier read adds status and UID.
  always_comb begin
    for (int i = 0; i < `TB_FRAME_MAX; i++) begin
      resp_nxt[i] = lnk.rx_buf[i];
    end
    resp_len_nxt = lnk.rx_len;
    if (attr_hit) begin
      resp_nxt[0] = {`TB_MBLI_NONE, lnk.rx_buf[`TB_POS_P4][3:0]};
      resp_len_nxt = `TB_IND_RESP_LEN;
      if (uid_rd) begin
        resp_nxt[1] = `TB_HL_STATUS_OK;
        for (int k = 0; k < 8; k++) begin
          resp_nxt[`TB_POS_UID_RESP + k] = uid_in[63 - 8 * k -: 8];
        end
        resp_len_nxt = `TB_UID_RESP_LEN;
      end
    end
  end

  // ----------------------------------------------------------------
  // State and selection data
  // ----------------------------------------------------------------
  // Anything not decoded leaves the state alone.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= st_idle;
    end else if (take) begin
      if (attr_hit) begin
        // Selection is the way into ACTIVE.
        state_r <= st_active;
      end else if (dsl_hit) begin
        state_r <= st_halt;
      end else if (req_hit) begin
        // A losing draw waits for the next request.
        state_r <= draw_win ? st_ready : st_idle;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      atqb_req_out <= 1'b0;
    end else begin
      atqb_req_out <= take && req_hit && draw_win;
    end
  end

  // Each direction keeps its own code.
  // Frame size nibble and parameter one are not used.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cid_out       <= 4'h0;
      cid_valid_out <= 1'b0;
      up_rate_out   <= 2'b00;
      down_rate_out <= 2'b00;
    end else if (take && attr_hit) begin
      cid_out       <= lnk.rx_buf[`TB_POS_P4][3:0];
      cid_valid_out <= 1'b1;
      up_rate_out   <= lnk.rx_buf[`TB_POS_P2][7:6];
      down_rate_out <= lnk.rx_buf[`TB_POS_P2][5:4];
    end
  end

  assign state_out = state_r;

  // ----------------------------------------------------------------
  // Response staging
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < `TB_FRAME_MAX; gi++) begin : g_resp
    always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
        tx_buf_r[gi] <= 8'h00;
      end else if (take && (attr_hit || dsl_hit)) begin
        tx_buf_r[gi] <= resp_nxt[gi];
      end
    end
    assign lnk.tx_buf[gi] = tx_buf_r[gi];
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tx_len_r <= 5'h00;
    end else if (take && (attr_hit || dsl_hit)) begin
      tx_len_r <= resp_len_nxt;
    end
  end

  // Fixed turnaround before the response starts.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pend_r   <= 1'b0;
      guard_r  <= 16'h0000;
      tx_tgl_r <= 1'b0;
    end else if (take && (attr_hit || dsl_hit)) begin
      pend_r  <= 1'b1;
      guard_r <= 16'(TR0_CYCLES);
    end else if (pend_r) begin
      if (guard_r <= 16'h0001) begin
        pend_r   <= 1'b0;
        tx_tgl_r <= !tx_tgl_r;
      end else begin
        guard_r <= guard_r - 16'h0001;
      end
    end
  end

  assign lnk.tx_len = tx_len_r;
  assign lnk.tx_tgl = tx_tgl_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  sequence s_take_attr;
    take && attr_hit;
  endsequence

  sequence s_take_dsl;
    take && dsl_hit;
  endsequence

  chk_attr_active: assert property (s_take_attr |=> state_r == st_active)
    else $error("Selection did not enter ACTIVE.");
  chk_attr_pupi: assert property (take && cmd == `TB_CMD_ATTRIB && !pupi_ok |=>
      $stable(state_r) && !pend_r)
    else $error("Selection with foreign PUPI was acted on.");
  chk_attr_ind: assert property (s_take_attr |=>
      tx_buf_r[0] == {`TB_MBLI_NONE, $past(lnk.rx_buf[`TB_POS_P4][3:0])} && cid_valid_out)
    else $error("Indicator byte wrong after selection.");
  chk_uid_append: assert property (s_take_attr ##0 uid_rd |=>
      tx_len_r == `TB_UID_RESP_LEN && tx_buf_r[1] == `TB_HL_STATUS_OK
      && {tx_buf_r[2], tx_buf_r[3]} == uid_in[63:48])
    else $error("Identifier read answer malformed.");
  chk_no_append: assert property (s_take_attr ##0 !uid_rd |=> tx_len_r == `TB_IND_RESP_LEN)
    else $error("Unexpected bytes appended to selection answer.");
  chk_rate_latch: assert property (s_take_attr |=>
      up_rate_out == $past(lnk.rx_buf[`TB_POS_P2][7:6])
      && down_rate_out == $past(lnk.rx_buf[`TB_POS_P2][5:4]))
    else $error("Rate codes not latched per direction.");
  chk_dsl_halt: assert property (s_take_dsl |=> state_r == st_halt
      && tx_len_r == $past(lnk.rx_len) && tx_buf_r[0] == $past(cmd))
    else $error("Release did not halt and echo.");
  chk_dsl_cid: assert property (take && state_r == st_active && cmd == `TB_CMD_DSL
      && cid_out != 4'h0 |=> state_r == st_active)
    else $error("Short release accepted with nonzero identifier.");
  chk_active_deaf: assert property (take && state_r == st_active && !dsl_hit |=>
      state_r == st_active && !atqb_req_out)
    else $error("ACTIVE reacted to a non-release frame.");
  chk_halt_deaf: assert property (take && state_r == st_halt
      && !prm[`TB_WUPB_BIT] |=> state_r == st_halt && !atqb_req_out)
    else $error("HALT answered a normal request.");
  chk_bad_crc: assert property (take && !lnk.rx_crc_ok |=>
      $stable(state_r) && !atqb_req_out && !pend_r)
    else $error("Frame with bad CRC changed state.");
  chk_slot_one: assert property (take && req_hit && prm[2:0] == 3'h0 |=> atqb_req_out)
    else $error("Single-slot request not answered.");
  chk_turnaround: assert property ($changed(tx_tgl_r) |-> $past(guard_r) <= 16'h0001
      && $past(pend_r))
    else $error("Response released before the turnaround.");
endmodule

/* verification/tbsel_reader_model.sv */
// Reader model: sends request frames on the link and collects the tag's response bytes.
module tbsel_reader_model (
  input  wire logic       link_clk_in, // Link clock.
  input  wire logic [7:0] tx_data_in,  // Response byte from the tag.
  input  wire logic       tx_valid_in, // Response byte valid.
  output logic      [7:0] data_out,    // Request byte.
  output logic            valid_out,   // Request byte strobe.
  output logic            eof_out,     // End of frame strobe.
  output logic            crc_ok_out,  // Frame check result.
  output logic            ready_out    // Takes a response byte.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] resp_q[$];
  logic       slow_r = 1'b0;
  logic       tick_r = 1'b0;
  initial begin
    data_out   = 8'h00;
    valid_out  = 1'b0;
    eof_out    = 1'b0;
    crc_ok_out = 1'b0;
    ready_out  = 1'b0;
  end
  // A slow reader takes a byte only every other link cycle, so the tag must hold it.
  always @(negedge link_clk_in) begin
    tick_r    <= ~tick_r;
    ready_out <= slow_r ? tick_r : 1'b1;
  end
  always @(posedge link_clk_in) begin
    if (tx_valid_in === 1'b1 && ready_out)
      resp_q.push_back(tx_data_in);
  end
  task automatic send(input logic [7:0] b[16], input int n, input logic good);
    for (int i = 0; i < n; i++) begin
      @(negedge link_clk_in);
      data_out  = b[i];
      valid_out = 1'b1;
    end
    @(negedge link_clk_in);
    // The released data line shows the inverse so a stale byte is never mistaken for data.
    data_out   = ~data_out;
    valid_out  = 1'b0;
    eof_out    = 1'b1;
    crc_ok_out = good;
    @(negedge link_clk_in);
    eof_out    = 1'b0;
    crc_ok_out = 1'b0;
  endtask
endmodule

/* verification/typeb_select_deselect_anticollision_tb_top.sv */
// Self-checking bench for the Type B selection, release and anticollision block.
module typeb_select_deselect_anticollision_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tbsel_pkg::*;
  logic clock_in = 1'b0, rst_in = 1'b1, link_clk_in = 1'b0;
  logic [7:0] rx_data, tx_data;
  logic rx_valid, rx_eof, rx_crc_ok, tx_ready, tx_valid, atqb;
  tbsel_state_t state;
  logic [3:0] cid;
  logic cid_valid;
  logic [1:0] up_rate, down_rate;
  logic [63:0] uid = 64'h0123_4567_89ab_cdef;
  int fail_count = 0, cmp_count = 0, atqb_cnt = 0, cyc = 0, wins = 0;
  initial forever #4 clock_in = ~clock_in;
  initial begin
    #5;
    forever #24 link_clk_in = ~link_clk_in;
  end
  tbsel_top #(.TR0_CYCLES(20)) u_tbsel_top (
    .clock_in(clock_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
    .lk_rx_data_in(rx_data), .lk_rx_valid_in(rx_valid), .lk_rx_eof_in(rx_eof),
    .lk_rx_crc_ok_in(rx_crc_ok), .lk_tx_ready_in(tx_ready), .uid_in(uid),
    .afi_in(8'h42), .lk_tx_data_out(tx_data), .lk_tx_valid_out(tx_valid),
    .atqb_req_out(atqb), .state_out(state), .cid_out(cid), .cid_valid_out(cid_valid),
    .up_rate_out(up_rate), .down_rate_out(down_rate));
  tbsel_reader_model u_tbsel_reader_model (
    .link_clk_in(link_clk_in), .tx_data_in(tx_data), .tx_valid_in(tx_valid),
    .data_out(rx_data), .valid_out(rx_valid), .eof_out(rx_eof),
    .crc_ok_out(rx_crc_ok), .ready_out(tx_ready));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Sends one frame, waits out turnaround and response, then checks the byte count.
  task automatic xfer(input logic [127:0] v, input int n, input logic good, input int exp_n);
    logic [7:0] b[16];
    for (int i = 0; i < 16; i++) b[i] = v[127-8*i -: 8];
    u_tbsel_reader_model.resp_q.delete();
    u_tbsel_reader_model.send(b, n, good);
    repeat (120) @(posedge link_clk_in);
    check(8'(u_tbsel_reader_model.resp_q.size()), 8'(exp_n));
  endtask
  task automatic resp(input int i, input logic [7:0] exp);
    check(u_tbsel_reader_model.resp_q[i], exp);
  endtask
  task automatic st(input logic [1:0] exp, input int exp_atqb);
    check({6'h00, state}, {6'h00, exp});
    check(8'(atqb_cnt), 8'(exp_atqb));
  endtask
  always @(posedge clock_in) begin
    if (atqb === 1'b1) atqb_cnt++;
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clock_in);
    @(negedge clock_in) rst_in = 1'b0;
    repeat (4) @(posedge link_clk_in);
    check({state, cid_valid, up_rate, down_rate, tx_valid}, 8'h00);
    check({cid, 3'h0, atqb}, 8'h00);
    xfer({8'h05, 8'h00, 8'h00, 104'h0}, 3, 1'b0, 0);
    st(st_idle, 0);
    xfer({8'h05, 8'h00, 8'h00, 104'h0}, 3, 1'b1, 0);
    st(st_ready, 1);
    // reader selects after the answer, parameter three 01h, identifier 5
    xfer({8'h1d, 32'h89abcdee, 8'h00, 8'h9f, 8'h01, 8'h05, 8'h30, 48'h0}, 10, 1'b1, 0);
    xfer({8'h1d, 32'h89abcdef, 8'h00, 8'h9f, 8'h01, 8'h05, 8'h30, 48'h0}, 10, 1'b0, 0);
    st(st_ready, 1);
    u_tbsel_reader_model.slow_r = 1'b1;
    xfer({8'h1d, 32'h89abcdef, 8'hff, 8'h9f, 8'h01, 8'h05, 8'h30, 48'h0}, 10, 1'b1, 10);
    resp(0, 8'h05);
    resp(1, 8'h00);
    for (int i = 0; i < 8; i++) resp(2 + i, uid[63-8*i -: 8]);
    check({cid_valid, 3'h0, cid}, 8'h85);
    check({4'h0, up_rate, down_rate}, 8'h09);
    xfer({8'h05, 8'h00, 8'h00, 104'h0}, 3, 1'b1, 0);
    xfer({8'h1d, 32'h89abcdef, 8'h00, 8'h00, 8'h01, 8'h03, 56'h0}, 9, 1'b1, 0);
    st(st_active, 1);
    xfer({8'hc2, 120'h0}, 1, 1'b1, 0);
    xfer({8'hca, 8'h03, 112'h0}, 2, 1'b1, 0);
    st(st_active, 1);
    xfer({8'hca, 8'h05, 112'h0}, 2, 1'b1, 2);
    resp(0, 8'hca);
    resp(1, 8'h05);
    st(st_halt, 1);
    u_tbsel_reader_model.slow_r = 1'b0;
    xfer({8'h05, 8'h00, 8'h00, 104'h0}, 3, 1'b1, 0);
    xfer({8'h05, 8'h17, 8'h08, 104'h0}, 3, 1'b1, 0);
    xfer({8'h1d, 32'h89abcdef, 8'h00, 8'h00, 8'h01, 8'h00, 56'h0}, 9, 1'b1, 0);
    st(st_halt, 1);
    xfer({8'h05, 8'h40, 8'h08, 104'h0}, 3, 1'b1, 0);
    st(st_ready, 2);
    xfer({8'h1d, 32'h89abcdef, 8'h00, 8'h00, 8'h01, 8'h00, 8'h31, 48'h0}, 10, 1'b1, 1);
    resp(0, 8'h00);
    xfer({8'hc2, 120'h0}, 1, 1'b1, 1);
    resp(0, 8'hc2);
    st(st_halt, 2);
    // the reader repeats wake-up requests with eight slots after a collision
    for (int k = 0; k < 24; k++) begin
      xfer({8'h05, 8'h00, 8'h0b, 104'h0}, 3, 1'b1, 0);
      if (atqb_cnt == 3 + wins) begin
        wins++;
        check({6'h00, state}, {6'h00, st_ready});
      end else check({6'h00, state}, {6'h00, st_idle});
    end
    check(8'((wins > 0) && (wins < 24)), 8'h01);
    report_and_stop();
  end
endmodule
